// ===== pkg/reset_wdt_map.svh
/*
  Register offsets, reset values, field positions and cycle counts for the
  reset filter and watchdog block.
  Assumes one clock that is the crystal clock; counts are in crystal periods.
*/
`ifndef RESET_WDT_MAP_SVH
`define RESET_WDT_MAP_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RW_BANK_F        4'hF
`define RW_CFG_ADDR      8'h0F
`define RW_STAT_ADDR     8'h0E
`define RW_CFG_RESET     5'h0D
`define RW_ST_EN_BIT     0
`define RW_ST_OPEN_BIT   1
`define RW_ST_WDCAUSE_BIT 2

// ----------------------------------------------------------------------
// Timing counts, in crystal periods (tap ends in watchdog counter ticks), and the reset vector
// ----------------------------------------------------------------------
`define RW_FILTER_CYC    8'h04
`define RW_DETECT_CYC    8'h04
`define RW_HOLD_CYC      8'h12
`define RW_START_CYC     8'h07
`define RW_WINDOW_CYC    6'h3C
`define RW_TAP0_LAST     12'h0FF
`define RW_TAP1_LAST     12'h1FF
`define RW_TAP2_LAST     12'h3FF
`define RW_TAP3_LAST     12'hFFF
`define RW_RESET_VECTOR  16'h000C

`endif

// ===== pkg/reset_wdt_pkg.sv
/*
  Types shared by the reset filter and watchdog block: sequencer states,
  watchdog configuration layout and the register request carrier.
  Assumes the constants of reset_wdt_map.svh are included where needed.
*/
package reset_wdt_pkg;

  // ----------------------------------------------------------------------
  // Reset sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_POR    = 6'b00_0001,
    ST_RUN    = 6'b00_0010,
    ST_FILTER = 6'b00_0100,
    ST_DETECT = 6'b00_1000,
    ST_HOLD   = 6'b01_0000,
    ST_START  = 6'b10_0000
  } seq_state_t;

  // Watchdog configuration, low five bits of the mode register
  typedef struct packed {
    logic counter_clock_select;
    logic active_in_stop;
    logic active_in_halt;
    logic timeout_select_hi;
    logic timeout_select_lo;
  } wdt_cfg_t;

  // Register port request
  typedef struct packed {
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// ===== logic/reset_filter_and_watchdog.sv
/*
  Reset filter, reset sequencer and watchdog timer of a small 8-bit core.
  Assumes: i_clock is the crystal clock; the reset pin and RC oscillator
  tick are asynchronous; refresh, halt, stop and register strobes come
  from core logic on i_clock. The pin is open drain, resolved outside.
*/
// Summary of operation
// - Execution starts 5 to 10 clocks after internal reset goes inactive.
// - First fetch after any reset is from address 000Ch.
// - Reset pin is synchronised to the clock before forming internal reset.
// - Four clocks after detection bring internal circuitry to reset.
// - Power-on timer holds reset and pulls the reset pin low.
// - Reset pin pulses shorter than four crystal periods are ignored.
// - Fifth clock latches reset; held 18 clocks or pin length, longer wins.
// - During reset data strobe stays low, address strobe toggles each clock.
// - Reset returns control registers to their defaults.
// - Watchdog is a retriggerable one-shot; run/halt timeout acts like a filtered pin reset.
// - First refresh enables watchdog, later ones restart; never disabled.
// - Mode bit 4 picks RC oscillator or crystal for the counter chain.
// - Refresh instruction updates zero, sign and overflow flags.
// - Mode register writable only 60 cycles after first instruction or stop recovery.
// - Mode register is write-only; reads give no contents.
// - Mode register sits at 0Fh of expanded bank F.
// - Time select taps give 256, 512, 1024 or 4096 clock periods.
// - After reset time select is high bit 0, low bit 1.
// - Mode register low bits reset to 01101.
// - Bit 2 keeps counting in halt, bit 3 keeps counting in stop.
// - Clock select 1 uses crystal, 0 uses RC oscillator.
// - Timeout in stop does not reset control registers.
`timescale 1ns/1ps
`include "reset_wdt_map.svh"

module reset_filter_and_watchdog #(
  parameter bit          HAS_POR_TIMER = 1'b1,
  parameter bit          PERMANENT_WDT = 1'b0,
  parameter logic [23:0] POR_HOLD_CYC  = 24'h00_1388
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic                    i_reset_pin_n,
  input  wire logic                    i_rc_osc,
  input  wire logic                    i_refresh,
  input  wire logic                    i_halt,
  input  wire logic                    i_stop,
  input  wire logic                    i_stop_exit,
  input  wire reset_wdt_pkg::reg_req_t i_bus,
  output logic [7:0]                   o_rdata,
  output logic                         o_core_reset_n,
  output logic                         o_ctrl_init,
  output logic                         o_fetch_start,
  output logic [15:0]                  o_fetch_addr,
  output logic                         o_data_strobe_n,
  output logic                         o_address_strobe_n,
  output logic                         o_flag_update,
  output logic                         o_stop_wake,
  output logic                         o_reset_pin_out,
  output logic                         o_reset_pin_oe
);
  import reset_wdt_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic pin_s1_q;
  logic pin_s2_q;
  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;
  logic pin_low;
  logic rc_edge;

  // Pin must pass two stages; reset only acts with the clock running
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= i_reset_pin_n;
      pin_s2_q <= pin_s1_q;
    end
  end

  // RC oscillator edges seen only after the second stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= i_rc_osc;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  assign pin_low = ~pin_s2_q;
  assign rc_edge = rc_s2_q & ~rc_s3_q;

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  seq_state_t  st_q;
  seq_state_t  st_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic [23:0] por_cnt_q;
  logic        wdt_rst;
  logic        in_reset_d;
  logic        start_done;

  // Next state; watchdog timeout outranks the pin filter
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_POR: begin
        if (por_cnt_q >= POR_HOLD_CYC - 24'h00_0001) begin
          st_d = ST_HOLD;
          cnt_d = 8'h00;
        end
      end
      ST_RUN: begin
        if (wdt_rst) begin
          st_d = ST_DETECT;
          cnt_d = 8'h00;
        end else if (pin_low) begin
          st_d = ST_FILTER;
          cnt_d = 8'h01;
        end
      end
      ST_FILTER: begin
        if (wdt_rst) begin
          st_d = ST_DETECT;
          cnt_d = 8'h00;
        end else if (!pin_low) begin
          st_d = ST_RUN;
        end else if (cnt_q == `RW_FILTER_CYC - 8'h01) begin
          st_d = ST_DETECT;
          cnt_d = 8'h00;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      ST_DETECT: begin
        // Four clocks of circuit reset, latch on the fifth
        if (cnt_q == `RW_DETECT_CYC - 8'h01) begin
          st_d = ST_HOLD;
          cnt_d = 8'h00;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      ST_HOLD: begin
        if (cnt_q < `RW_HOLD_CYC - 8'h01) begin
          cnt_d = cnt_q + 8'h01;
        end else if (!pin_low) begin
          st_d = ST_START;
          cnt_d = 8'h00;
        end
      end
      ST_START: begin
        // Pin activity here is caught by the filter once running
        if (cnt_q == `RW_START_CYC - 8'h01) begin
          st_d = ST_RUN;
          cnt_d = 8'h00;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      default: begin
        st_d = ST_HOLD;
        cnt_d = 8'h00;
      end
    endcase
  end

  assign in_reset_d = (st_d == ST_POR) || (st_d == ST_DETECT) || (st_d == ST_HOLD);
  assign start_done = (st_q == ST_START) && (st_d == ST_RUN);

  // State and step counter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q <= HAS_POR_TIMER ? ST_POR : ST_HOLD;
      cnt_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Power-on hold counter; long, so a parameter sets it
  always_ff @(posedge i_clock) begin
    if (i_rst || st_q != ST_POR) begin
      por_cnt_q <= 24'h00_0000;
    end else begin
      por_cnt_q <= por_cnt_q + 24'h00_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Reset outputs and strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_core_reset_n <= 1'b0;
      o_ctrl_init <= 1'b1;
      o_reset_pin_oe <= HAS_POR_TIMER;
      o_reset_pin_out <= 1'b0;
    end else begin
      o_core_reset_n <= !((st_d == ST_POR) || (st_d == ST_HOLD));
      o_ctrl_init <= in_reset_d;
      o_reset_pin_oe <= (st_d == ST_POR);
      o_reset_pin_out <= 1'b0;
    end
  end

  // Strobes idle high outside reset; the core drives its own otherwise
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_data_strobe_n <= 1'b0;
      o_address_strobe_n <= 1'b1;
    end else begin
      o_data_strobe_n <= !in_reset_d;
      o_address_strobe_n <= in_reset_d ? ~o_address_strobe_n : 1'b1;
    end
  end

  // Vector start pulse
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_fetch_start <= 1'b0;
      o_fetch_addr <= `RW_RESET_VECTOR;
    end else begin
      o_fetch_start <= start_done;
      o_fetch_addr <= `RW_RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------------
  wdt_cfg_t   cfg_q;
  logic       wdt_en_q;
  logic [11:0] wcnt_q;
  logic [11:0] tap_last;
  logic       tick;
  logic       gate;
  logic       running;
  logic       fire;
  logic       refresh_ok;

  assign refresh_ok = i_refresh && (st_q == ST_RUN);

  // Selected tap end
  always_comb begin
    case ({cfg_q.timeout_select_hi, cfg_q.timeout_select_lo})
      2'b00:   tap_last = `RW_TAP0_LAST;
      2'b01:   tap_last = `RW_TAP1_LAST;
      2'b10:   tap_last = `RW_TAP2_LAST;
      default: tap_last = `RW_TAP3_LAST;
    endcase
  end

  // Crystal counts every clock; RC counts its synchronised edges
  assign tick = cfg_q.counter_clock_select ? 1'b1 : rc_edge;
  assign gate = i_stop ? cfg_q.active_in_stop :
                i_halt ? cfg_q.active_in_halt : 1'b1;
  assign running = wdt_en_q && (st_q == ST_RUN) && gate && tick;
  assign fire = running && !refresh_ok && (wcnt_q == tap_last);
  assign wdt_rst = fire && !i_stop;

  // Enable latches for good; only power-on clears it
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wdt_en_q <= PERMANENT_WDT;
    end else if (refresh_ok) begin
      wdt_en_q <= 1'b1;
    end
  end

  // One-shot count, restarted by refresh or any reset
  always_ff @(posedge i_clock) begin
    if (i_rst || st_q != ST_RUN || refresh_ok) begin
      wcnt_q <= 12'h000;
    end else if (running) begin
      wcnt_q <= fire ? 12'h000 : wcnt_q + 12'h001;
    end
  end

  // Flag update and stop wake pulses
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_flag_update <= 1'b0;
      o_stop_wake <= 1'b0;
    end else begin
      o_flag_update <= refresh_ok;
      o_stop_wake <= fire && i_stop;
    end
  end

  // ----------------------------------------------------------------------
  // Mode register and write window
  // ----------------------------------------------------------------------
  logic       win_open_q;
  logic [5:0] win_cnt_q;
  logic       cfg_hit;
  logic       stat_hit;
  logic       cfg_wr;
  logic       wd_cause_q;
  logic [7:0] status;

  assign cfg_hit = (i_bus.bank == `RW_BANK_F) && (i_bus.addr == `RW_CFG_ADDR);
  assign stat_hit = (i_bus.bank == `RW_BANK_F) && (i_bus.addr == `RW_STAT_ADDR);
  assign cfg_wr = i_bus.wr && cfg_hit && win_open_q && (st_q == ST_RUN);

  // Window opens at first instruction and at stop recovery
  always_ff @(posedge i_clock) begin
    if (i_rst || st_q != ST_RUN && !start_done) begin
      win_open_q <= 1'b0;
      win_cnt_q <= 6'h00;
    end else if (start_done || o_stop_wake || i_stop_exit) begin
      win_open_q <= 1'b1;
      win_cnt_q <= 6'h00;
    end else if (win_open_q) begin
      win_cnt_q <= win_cnt_q + 6'h01;
      win_open_q <= (win_cnt_q != `RW_WINDOW_CYC - 6'h01);
    end
  end

  // Defaults on every reset that clears control registers
  always_ff @(posedge i_clock) begin
    if (i_rst || st_q == ST_DETECT) begin
      cfg_q <= `RW_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= i_bus.wdata[4:0];
    end
  end

  // Remembers whether the last reset came from the watchdog
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wd_cause_q <= 1'b0;
    end else if (wdt_rst) begin
      wd_cause_q <= 1'b1;
    end else if (st_q == ST_FILTER && st_d == ST_DETECT) begin
      wd_cause_q <= 1'b0;
    end
  end

  // Status word
  always_comb begin
    status = 8'h00;
    status[`RW_ST_EN_BIT] = wdt_en_q;
    status[`RW_ST_OPEN_BIT] = win_open_q;
    status[`RW_ST_WDCAUSE_BIT] = wd_cause_q;
  end

  // Read data one cycle later; mode register reads as zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd && stat_hit) begin
      o_rdata <= status;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [7:0] low_cnt_q;

  // Length of the current internal reset, saturating
  always_ff @(posedge i_clock) begin
    if (i_rst || o_core_reset_n) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  start_delay_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_core_reset_n) |-> ##[5:10] o_fetch_start)
    else $error("fetch not 5 to 10 clocks after reset release");

  fetch_vector_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_fetch_start |-> o_fetch_addr == `RW_RESET_VECTOR && o_core_reset_n)
    else $error("first fetch not at reset vector");

  short_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (st_q == ST_FILTER && !pin_low && !wdt_rst) |=> st_q == ST_RUN && o_ctrl_init == 1'b0)
    else $error("short reset pulse not ignored");

  detect_len_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(st_q == ST_DETECT) |-> (st_q == ST_DETECT)[*4] ##1 !o_core_reset_n)
    else $error("detect phase not four clocks");

  hold_min_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_core_reset_n) |-> low_cnt_q >= `RW_HOLD_CYC && !$past(pin_low))
    else $error("internal reset released too early");

  reset_strobe_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (!o_core_reset_n ##1 !o_core_reset_n) |->
      !o_data_strobe_n && o_address_strobe_n != $past(o_address_strobe_n))
    else $error("strobes wrong during reset");

  wdt_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wdt_rst |=> st_q == ST_DETECT ##5 !o_core_reset_n)
    else $error("watchdog timeout did not reset");

  refresh_a: assert property (@(posedge i_clock) disable iff (i_rst)
    refresh_ok |=> wcnt_q == 12'h000 && wdt_en_q && o_flag_update)
    else $error("refresh did not restart watchdog");

  cfg_lock_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_bus.wr && cfg_hit && !win_open_q && st_q == ST_RUN) |=> cfg_q == $past(cfg_q))
    else $error("mode register changed after window");

  cfg_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_bus.rd && cfg_hit) |=> o_rdata == 8'h00)
    else $error("mode register contents visible on read");

  stop_wake_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (fire && i_stop) |=> st_q == ST_RUN && o_stop_wake && o_core_reset_n)
    else $error("stop timeout reset control registers");

endmodule // reset_filter_and_watchdog

// ===== tb/reset_source_model.sv
/*
  Behavioural reset circuit at the far side of the reset pin.
  Assumes an open-drain pin with a pull-up; the device may pull it low too.
*/
`timescale 1ns/1ps

module reset_source_model (
  input  wire logic       i_clock,
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  input  wire logic       i_dev_out,
  input  wire logic       i_dev_oe,
  output logic            o_pin_n
);
  logic [7:0] low_cnt_q = 8'h00;

  // Pull the pin low for the requested number of clocks
  always_ff @(posedge i_clock) begin
    if (i_go)
      low_cnt_q <= i_len;
    else if (low_cnt_q != 8'h00)
      low_cnt_q <= low_cnt_q - 8'h01;
  end

  // Wired-and with pull-up: a released pin reads high, never a held value
  assign o_pin_n = !((low_cnt_q != 8'h00) || (i_dev_oe && !i_dev_out));
endmodule // reset_source_model

// ===== tb/tb.sv
/*
  Self-checking bench for the reset filter and watchdog block.
  Assumes a 100 MHz crystal clock, an RC tick of 4 clocks and a short POR hold.
*/
`timescale 1ns/1ps
`include "reset_wdt_map.svh"

module tb;
  import reset_wdt_pkg::*;
  logic        i_clock, i_rst, i_rc_osc, i_refresh, i_halt, i_stop, go, pin_n;
  logic [7:0]  len, o_rdata, rd;
  logic [15:0] o_fetch_addr;
  reg_req_t    i_bus;
  logic        o_core_reset_n, o_ctrl_init, o_fetch_start, o_data_strobe_n;
  logic        o_address_strobe_n, o_flag_update, o_stop_wake, o_reset_pin_out;
  logic        o_reset_pin_oe;
  logic        stop_exit;
  int          err_count = 0;
  int          n_tests = 0;

  // ----------------------------------------------------------------------
  // Clocks, design and partner
  // ----------------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // RC tick, off phase from the crystal on purpose
  initial begin
    i_rc_osc = 1'b0;
    #3;
    forever #20 i_rc_osc = ~i_rc_osc;
  end

  reset_filter_and_watchdog #(.POR_HOLD_CYC(24'h00_0014)) u_reset_filter_and_watchdog (
    .i_clock(i_clock), .i_rst(i_rst), .i_reset_pin_n(pin_n), .i_rc_osc(i_rc_osc),
    .i_refresh(i_refresh), .i_halt(i_halt), .i_stop(i_stop), .i_stop_exit(stop_exit),
    .i_bus(i_bus), .o_rdata(o_rdata), .o_core_reset_n(o_core_reset_n),
    .o_ctrl_init(o_ctrl_init), .o_fetch_start(o_fetch_start), .o_fetch_addr(o_fetch_addr),
    .o_data_strobe_n(o_data_strobe_n), .o_address_strobe_n(o_address_strobe_n),
    .o_flag_update(o_flag_update), .o_stop_wake(o_stop_wake),
    .o_reset_pin_out(o_reset_pin_out), .o_reset_pin_oe(o_reset_pin_oe));

  reset_source_model u_reset_source_model (
    .i_clock(i_clock), .i_go(go), .i_len(len), .i_dev_out(o_reset_pin_out),
    .i_dev_oe(o_reset_pin_oe), .o_pin_n(pin_n));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Sample just after the edge so registered outputs have landed
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask

  // Count clocks until reset init (or stop wake) shows; a needed one that never comes ends the run
  task automatic wait_sig(input bit wake, input bit must, input int max, output int cnt);
    cnt = 0;
    while (((wake ? o_stop_wake : o_ctrl_init) !== 1'b1) && cnt < max) begin
      tick();
      cnt++;
    end
    if (must && cnt >= max) begin
      err_count++;
      $display("unexpected wait length: expected below %0d, seen %0d", max, cnt);
      wrap_up();
    end
  endtask

  task automatic bus_wr(input logic [7:0] addr, input logic [7:0] data);
    i_bus <= '{bank: `RW_BANK_F, addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    tick();
    i_bus <= '0;
    tick();
  endtask

  task automatic bus_rd(input logic [7:0] addr, output logic [7:0] data);
    i_bus <= '{bank: `RW_BANK_F, addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    tick();
    data = o_rdata;
    i_bus <= '0;
    tick();
  endtask

  task automatic refresh();
    i_refresh <= 1'b1;
    tick();
    i_refresh <= 1'b0;
    chk("flag update", 16'h0001, {15'h0000, o_flag_update});
  endtask

  task automatic pin_low(input logic [7:0] n);
    len <= n;
    go  <= 1'b1;
    tick();
    go  <= 1'b0;
  endtask

  // One reset cycle from init to first fetch, with strobe watch on every clock of reset
  task automatic follow_reset(output int det, output int low, output int st);
    int   bad;
    logic as_p;
    logic in_p;
    det = 0; low = 0; st = 0; bad = 0;
    as_p = o_address_strobe_n;
    in_p = (o_ctrl_init === 1'b1);
    while (o_core_reset_n !== 1'b0 && det < 300) begin
      tick(); det++;
      if (in_p && o_ctrl_init === 1'b1 &&
          (o_data_strobe_n !== 1'b0 || o_address_strobe_n === as_p)) bad++;
      as_p = o_address_strobe_n; in_p = (o_ctrl_init === 1'b1);
    end
    while (o_core_reset_n !== 1'b1 && low < 300) begin
      tick(); low++;
      if (in_p && o_ctrl_init === 1'b1 &&
          (o_data_strobe_n !== 1'b0 || o_address_strobe_n === as_p)) bad++;
      as_p = o_address_strobe_n; in_p = (o_ctrl_init === 1'b1);
    end
    while (o_fetch_start !== 1'b1 && st < 300) begin
      tick(); st++;
    end
    chk("strobe faults", 16'h0000, 16'(bad));
    chk("fetch address", `RW_RESET_VECTOR, o_fetch_addr);
    chk_rng("start delay", 5, 10, st);
    // Any phase that never ends is a hang, not a slow reset
    if (det >= 300 || low >= 300 || st >= 300) begin
      err_count++;
      $display("unexpected reset phase length: expected below 300, seen %0d", det + low + st);
      wrap_up();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_por();
    int d, l, s;
    chk("pin drive", 16'h0001, {15'h0000, o_reset_pin_oe});
    chk("pin level", 16'h0000, {15'h0000, pin_n});
    chk("pin drive level", 16'h0000, {15'h0000, o_reset_pin_out});
    follow_reset(d, l, s);
    chk_rng("power-on hold", 38, 60, l);
    chk("pin released", 16'h0000, {15'h0000, o_reset_pin_oe});
    bus_rd(`RW_CFG_ADDR, rd);
    chk("config read", 16'h0000, {8'h00, rd});
    bus_rd(`RW_STAT_ADDR, rd);
    chk("status", 16'h0002, {8'h00, rd});
    bus_rd(8'h0D, rd);
    chk("unmapped read", 16'h0000, {8'h00, rd});
    $display("test power-on done");
  endtask

  task automatic t_pin();
    int c, d, l, s;
    pin_low(8'h03);
    wait_sig(1'b0, 1'b0, 30, c);
    chk_rng("short pulse quiet", 30, 30, c);
    pin_low(8'h04);
    wait_sig(1'b0, 1'b1, 30, c);
    follow_reset(d, l, s);
    chk_rng("detect delay", 4, 5, d);
    chk_rng("minimum hold", 18, 19, l);
    pin_low(8'h50);
    wait_sig(1'b0, 1'b1, 30, c);
    follow_reset(d, l, s);
    chk_rng("held by pin", 68, 78, l);
    $display("test pin done");
  endtask

  task automatic t_watchdog();
    int c, d, l, s;
    bus_wr(`RW_CFG_ADDR, 8'h10);
    refresh();
    i_halt <= 1'b1;
    wait_sig(1'b0, 1'b0, 400, c);
    chk_rng("halt gated", 400, 400, c);
    i_halt <= 1'b0;
    tick(200);
    refresh();
    wait_sig(1'b0, 1'b1, 300, c);
    chk_rng("tap 256 timeout", 255, 262, c);
    follow_reset(d, l, s);
    chk_rng("watchdog detect", 4, 5, d);
    bus_rd(`RW_STAT_ADDR, rd);
    chk("status after timeout", 16'h0007, {8'h00, rd});
    $display("test watchdog done");
  endtask

  task automatic t_late();
    int c, d, l, s;
    tick(70);
    bus_rd(`RW_STAT_ADDR, rd);
    chk("window closed", 16'h0005, {8'h00, rd});
    bus_wr(`RW_CFG_ADDR, 8'h10);
    refresh();
    wait_sig(1'b0, 1'b1, 3000, c);
    chk_rng("default rc timeout", 2030, 2070, c);
    follow_reset(d, l, s);
    $display("test late write done");
  endtask

  task automatic t_stop();
    int c;
    bus_wr(`RW_CFG_ADDR, 8'h18);
    refresh();
    i_stop <= 1'b1;
    wait_sig(1'b1, 1'b1, 300, c);
    chk_rng("stop wake time", 255, 262, c);
    wait_sig(1'b0, 1'b0, 20, c);
    chk_rng("no reset in stop", 20, 20, c);
    i_stop <= 1'b0;
    // Window reopened by the wake closes again, then stop recovery reopens it
    tick(70);
    bus_rd(`RW_STAT_ADDR, rd);
    chk("window after wake", 16'h0005, {8'h00, rd});
    stop_exit <= 1'b1;
    tick();
    stop_exit <= 1'b0;
    bus_rd(`RW_STAT_ADDR, rd);
    chk("window after recovery", 16'h0007, {8'h00, rd});
    $display("test stop done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------------
  initial begin
    i_rst = 1'b1; i_refresh = 1'b0; i_halt = 1'b0; i_stop = 1'b0;
    go = 1'b0; len = 8'h00; i_bus = '0; stop_exit = 1'b0;
    tick(16);
    // Power-on hold is timed from this release, so follow it at once
    i_rst <= 1'b0;
    t_por();
    t_pin();
    t_watchdog();
    t_late();
    t_stop();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge i_clock);
    err_count++;
    $display("unexpected run length: expected below 100000, seen 100000");
    wrap_up();
  end
endmodule // tb
